// ===== pkg/cmrro_pkg.sv
/*
 * cmrro_pkg: constants and carriers for the move/return/rotate executor.
 * assumes a 12-bit instruction word and an 8-bit data path.
 */
package cmrro_pkg;
    // ---------------------------------------------------------------
    // widths and encodings
    // ---------------------------------------------------------------
    localparam int          INSN_W       = 12;
    localparam int          DATA_W       = 8;
    localparam int          FADDR_W      = 5;
    localparam int          PC_W         = 11;
    localparam int          STACK_DEPTH  = 2;
    localparam logic [11:0] IDLE_WORD    = 12'h000;
    localparam logic [11:0] OPTION_WORD  = 12'h002;
    localparam logic [6:0]  STORE_TOP7   = 7'h01;   // word[11:5] of store
    localparam logic [3:0]  RETLIT_TOP4  = 4'h8;    // word[11:8] of return
    localparam logic [5:0]  ROTATE_TOP6  = 6'h0D;   // word[11:6] of rotate
    localparam int          DEST_BIT     = 5;
    localparam int          CARRY_BIT    = 0;
    localparam logic [10:0] PC_STEP      = 11'h001;
    localparam logic [7:0]  DATA_ZERO    = 8'h00;
    localparam logic [7:0]  OPTION_RESET = 8'hFF;

    // decoded operation, one-hot
    typedef enum logic [4:0] {
        CMRRO_OP_IDLE   = 5'h01,
        CMRRO_OP_STORE  = 5'h02,
        CMRRO_OP_OPTION = 5'h04,
        CMRRO_OP_RETLIT = 5'h08,
        CMRRO_OP_ROTATE = 5'h10
    } cmrro_op_t;

    // file register write request toward the register file
    typedef struct packed {
        logic                 wrEn;
        logic [FADDR_W-1:0]   addr;
        logic [DATA_W-1:0]    data;
    } cmrro_fwr_t;
endpackage : cmrro_pkg

// ===== hw/cmrro_decode.sv
/*
 * cmrro_decode: combinational decoder of one instruction word.
 * assumes words outside the five handled ones are executed elsewhere.
 */
`timescale 1ns/1ps
module cmrro_decode
    import cmrro_pkg::*;
(
    // instruction in
    input  wire logic [INSN_W-1:0] insn,
    // decoded result
    output cmrro_op_t              op,
    output logic                   known
);
    // -----------------------------------------------------------------
    // pattern match
    // -----------------------------------------------------------------
    always_comb begin
        known = 1'b1;
        if (insn == IDLE_WORD) begin
            op = CMRRO_OP_IDLE;
        end else if (insn == OPTION_WORD) begin
            op = CMRRO_OP_OPTION;
        end else if (insn[11:5] == STORE_TOP7) begin
            op = CMRRO_OP_STORE;
        end else if (insn[11:8] == RETLIT_TOP4) begin
            op = CMRRO_OP_RETLIT;
        end else if (insn[11:6] == ROTATE_TOP6) begin
            op = CMRRO_OP_ROTATE;
        end else begin
            // foreign word: treated as idle here
            op    = CMRRO_OP_IDLE;
            known = 1'b0;
        end
    end
endmodule : cmrro_decode

// ===== hw/cmrro_core.sv
/*
 * cmrro_core: executes store, idle, option load, literal return and
 * rotate-left-through-carry on one instruction word per cycle.
 * assumes the fetch unit supplies the word plus the addressed file
 * register value in the same cycle, and honours the flush output.
 */
// Operation
// (RULE1) store working register into addressed file
// (RULE2) option load copies working register, one cycle
// (RULE3) literal return loads literal into working
// (RULE4) literal return pops stack top into pc
// (RULE5) literal return two cycles, next fetch flushed
// (RULE6) rotate left through carry, status bit 0
// (RULE7) destination bit selects working or file
// (RULE8) idle word changes nothing, pc increments
`timescale 1ns/1ps
module cmrro_core
    import cmrro_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    // fetched instruction
    input  wire logic              insnValid,
    input  wire logic [INSN_W-1:0] insnWord,
    // file register read data for the addressed register
    input  wire logic [DATA_W-1:0] fileRdData,
    // call push from the fetch/call logic
    input  wire logic              pushEn,
    input  wire logic [PC_W-1:0]   pushAddr,
    // architectural state out
    output logic [DATA_W-1:0]      workReg,
    output logic [DATA_W-1:0]      optionReg,
    output logic                   carryFlag,
    output logic [PC_W-1:0]        progCnt,
    output cmrro_fwr_t             fileWr,
    output logic                   flushFetch
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] work;       // working register
        logic [DATA_W-1:0] option;     // option register
        logic              carry;      // status carry
        logic [PC_W-1:0]   pc;         // program counter
        logic [PC_W-1:0]   stk0;       // stack_top
        logic [PC_W-1:0]   stk1;       // second level
        cmrro_fwr_t        fwr;        // registered file write
        logic              flush;      // discard slot of return
    } cmrro_state_t;

    cmrro_state_t st_q;                // registered state
    cmrro_state_t st_d;                // next state
    cmrro_op_t    op;                  // decoded op
    logic         known;               // word is one of ours
    logic         exec;                // word executes this cycle

    // decoder instance
    cmrro_decode i_cmrro_decode (
        .insn  (insnWord),
        .op    (op),
        .known (known)
    );

    // discarded slot never executes
    assign exec = insnValid && !st_q.flush;

    // rotate helper: {new carry, result}
    function automatic logic [DATA_W:0] rotl(input logic [DATA_W-1:0] v, input logic c);
        rotl = {v, c};
    endfunction : rotl

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    // one copy of the state, filled from the decoded word
    always_comb begin
        logic [DATA_W:0] rot;
        rot            = rotl(fileRdData, st_q.carry);
        st_d           = st_q;
        st_d.fwr.wrEn  = 1'b0;
        st_d.flush     = 1'b0;
        // call push from the outside
        if (pushEn) begin
            st_d.stk1 = st_q.stk0;
            st_d.stk0 = pushAddr;
        end
        // executing word: default pc step, then per operation
        if (exec) begin
            st_d.pc = st_q.pc + PC_STEP;
            case (op)
                // (RULE8) idle no effect
                CMRRO_OP_IDLE: begin
                    st_d.pc = st_q.pc + PC_STEP;
                end
                // (RULE1) store working reg
                CMRRO_OP_STORE: begin
                    st_d.fwr.wrEn = 1'b1;
                    st_d.fwr.addr = insnWord[FADDR_W-1:0];
                    st_d.fwr.data = st_q.work;
                end
                // (RULE2) option load
                CMRRO_OP_OPTION: begin
                    st_d.option = st_q.work;
                end
                // (RULE3) (RULE4) (RULE5) literal return and pop
                // a push in the same cycle loses stk0 to the pop
                CMRRO_OP_RETLIT: begin
                    st_d.work  = insnWord[DATA_W-1:0];
                    st_d.pc    = st_q.stk0;
                    st_d.stk0  = st_q.stk1;
                    st_d.flush = 1'b1;
                end
                // (RULE6) (RULE7) rotate through carry
                CMRRO_OP_ROTATE: begin
                    st_d.carry = rot[DATA_W];
                    if (insnWord[DEST_BIT]) begin
                        st_d.fwr.wrEn = 1'b1;
                        st_d.fwr.addr = insnWord[FADDR_W-1:0];
                        st_d.fwr.data = rot[DATA_W-1:0];
                    end else begin
                        st_d.work = rot[DATA_W-1:0];
                    end
                end
                default: begin
                    st_d.pc = st_q.pc + PC_STEP;
                end
            endcase
        end else if (insnValid) begin
            // flushed slot holds the pc on the discarded fetch
            st_d.pc = st_q.pc;
        end
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    // asynchronous clear to reset values, then register the copy
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '{work: DATA_ZERO, option: OPTION_RESET, carry: 1'b0,
                      pc: '0, stk0: '0, stk1: '0,
                      fwr: '{wrEn: 1'b0, addr: '0, data: DATA_ZERO}, flush: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    assign workReg    = st_q.work;
    assign optionReg  = st_q.option;
    assign carryFlag  = st_q.carry;
    assign progCnt    = st_q.pc;
    assign fileWr     = st_q.fwr;
    assign flushFetch = st_q.flush;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    // all checks on the core clock, silent while in reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // store lands one cycle later with the old working value
    store_write_a: assert property (exec && op == CMRRO_OP_STORE |=>   // (RULE1)
        fileWr.wrEn && fileWr.data == $past(st_q.work) && fileWr.addr == $past(insnWord[4:0])
        && carryFlag == $past(st_q.carry))
        else $error("store did not write working register");
    // option copy in one cycle, carry untouched
    option_load_a: assert property (exec && op == CMRRO_OP_OPTION |=>  // (RULE2)
        optionReg == $past(st_q.work) && carryFlag == $past(st_q.carry))
        else $error("option load wrong");
    retlit_work_a: assert property (exec && op == CMRRO_OP_RETLIT |=>  // (RULE3)
        workReg == $past(insnWord[7:0]))
        else $error("literal not loaded");
    retlit_pop_a: assert property (exec && op == CMRRO_OP_RETLIT && !pushEn |=> // (RULE4)
        progCnt == $past(st_q.stk0) && st_q.stk0 == $past(st_q.stk1))
        else $error("stack top not popped");
    // exactly one discarded slot after a return
    retlit_flush_a: assert property (exec && op == CMRRO_OP_RETLIT |=> // (RULE5)
        flushFetch ##1 !flushFetch)
        else $error("return slot not discarded once");
    // old bit 7 becomes the carry
    rotate_carry_a: assert property (exec && op == CMRRO_OP_ROTATE |=> // (RULE6)
        carryFlag == $past(fileRdData[7]))
        else $error("rotate carry wrong");
    rotate_dest_a: assert property (exec && op == CMRRO_OP_ROTATE && !insnWord[5] |=> // (RULE7)
        workReg == {$past(fileRdData[6:0]), $past(st_q.carry)} && !fileWr.wrEn)
        else $error("rotate to working wrong");
    // idle and foreign words only step the pc
    idle_still_a: assert property (exec && op == CMRRO_OP_IDLE && !pushEn |=> // (RULE8)
        progCnt == $past(st_q.pc) + PC_STEP && $stable(workReg) && $stable(carryFlag)
        && $stable(optionReg) && !fileWr.wrEn)
        else $error("idle changed state");

    // -----------------------------------------------------------------
    // refused slot and remaining destinations
    // -----------------------------------------------------------------
    // a word in the slot after a return must leave all state alone
    flushed_slot_a: assert property (st_q.flush && insnValid |=>     // (RULE5)
        progCnt == $past(st_q.pc) && $stable(workReg) && $stable(optionReg)
        && $stable(carryFlag) && !fileWr.wrEn && !flushFetch)
        else $error("discarded slot changed state");
    // file destination writes back and leaves the working register
    rotate_file_a: assert property (exec && op == CMRRO_OP_ROTATE && insnWord[5] |=> // (RULE7)
        fileWr.wrEn && fileWr.data == {$past(fileRdData[6:0]), $past(st_q.carry)}
        && fileWr.addr == $past(insnWord[4:0]) && $stable(workReg))
        else $error("rotate to file wrong");
    // literal return keeps the carry and writes no file
    retlit_flags_a: assert property (exec && op == CMRRO_OP_RETLIT |=> // (RULE3)
        carryFlag == $past(st_q.carry) && !fileWr.wrEn)
        else $error("literal return touched flags");

    // -----------------------------------------------------------------
    // scenarios reached
    // -----------------------------------------------------------------
    // store, return pair, rotate to file, discarded slot, foreign word
    cov_store_c:   cover property (exec && op == CMRRO_OP_STORE);
    cov_retlit_c:  cover property (exec && op == CMRRO_OP_RETLIT ##2 exec);
    cov_rotf_c:    cover property (exec && op == CMRRO_OP_ROTATE && insnWord[5]);
    cov_flush_c:   cover property (st_q.flush && insnValid);
    cov_foreign_c: cover property (exec && !known);
endmodule : cmrro_core

// ===== tb/cmrro_file_model.sv
/*
 * file register array on the far side.
 * assumes writes land one edge after the request.
 */
`timescale 1ns/1ps
module cmrro_file_model
    import cmrro_pkg::*;
(
    // clock
    input  wire logic              core_clk,
    // address and write request
    input  wire logic [INSN_W-1:0] insnWord,
    input  wire cmrro_fwr_t        fileWr,
    // addressed value
    output logic [DATA_W-1:0]      fileRdData
);
    logic [DATA_W-1:0] mem [32];   // contents
    // clear at start
    initial begin
        for (int i = 0; i < 32; i++) begin
            mem[i] = DATA_ZERO;
        end
    end
    // take written results
    always @(posedge core_clk) begin
        if (fileWr.wrEn === 1'b1) begin
            mem[fileWr.addr] <= fileWr.data;
        end
    end
    // addressed value, same cycle
    assign fileRdData = mem[insnWord[FADDR_W-1:0]];
endmodule : cmrro_file_model

// ===== tb/cpu_move_return_rotate_ops_tb.sv
/*
 * directed bench for the executor.
 * assumes the file model; inputs change on falling edges.
 */
`timescale 1ns/1ps
module cpu_move_return_rotate_ops_tb;
    import cmrro_pkg::*;
    // ----------------------------------------------
    // signals
    // ----------------------------------------------
    logic              core_clk   = 1'b0;       // 25 MHz
    logic              rst_b      = 1'b0;       // reset
    logic              insnValid  = 1'b0;       // word present
    logic [INSN_W-1:0] insnWord   = IDLE_WORD;  // word
    logic              pushEn     = 1'b0;       // push strobe
    logic [PC_W-1:0]   pushAddr   = 11'h000;    // pushed address
    logic [DATA_W-1:0] fileRdData;              // file value
    logic [DATA_W-1:0] workReg;                 // state out
    logic [DATA_W-1:0] optionReg;
    logic              carryFlag;
    logic              flushFetch;
    logic [PC_W-1:0]   progCnt;
    cmrro_fwr_t        fileWr;                  // write request
    logic [PC_W-1:0]   pcOld;                   // pc before a word
    int                errTotal   = 0;          // mismatches
    int                cmpCount   = 0;          // comparisons
    // clock
    always #20 core_clk = ~core_clk;
    cmrro_core i_cmrro_core (.core_clk(core_clk), .rst_b(rst_b), .insnValid(insnValid),
        .insnWord(insnWord), .fileRdData(fileRdData), .pushEn(pushEn), .pushAddr(pushAddr),
        .workReg(workReg), .optionReg(optionReg), .carryFlag(carryFlag), .progCnt(progCnt),
        .fileWr(fileWr), .flushFetch(flushFetch));
    cmrro_file_model i_cmrro_file_model (.core_clk(core_clk), .insnWord(insnWord),
        .fileWr(fileWr), .fileRdData(fileRdData));
    // compare and report
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one word, taken at the next rising edge
    task automatic run(input logic [INSN_W-1:0] w);
        pcOld     = progCnt;
        insnWord  = w;
        insnValid = 1'b1;
        @(negedge core_clk);
    endtask : run
    // one empty cycle
    task automatic gap();
        insnValid = 1'b0;
        @(negedge core_clk);
    endtask : gap
    // one call push pulse
    task automatic push(input logic [PC_W-1:0] a);
        pushEn   = 1'b1;
        pushAddr = a;
        @(negedge core_clk);
        pushEn   = 1'b0;
        @(negedge core_clk);
    endtask : push
    task automatic t_return();
        push(11'h123);
        push(11'h055);
        run(12'h8A5);
        chk("work", workReg, 16'h00A5);
        chk("pc", progCnt, 16'h0055);
        chk("flush", flushFetch, 16'h1);
        run(12'h03F);
        chk("wrEn", fileWr.wrEn, 16'h0);
        chk("pc", progCnt, 16'h0055);
        run(12'h8E6);
        chk("pc", progCnt, 16'h0123);
        gap();
    endtask : t_return
    task automatic t_store();
        run(12'h03F);
        chk("fileWr", fileWr, {1'b1, 5'h1F, 8'hE6});
        chk("pc", progCnt, pcOld + 11'h001);
        run(12'h020);
        chk("fileWr", fileWr, {1'b1, 5'h00, 8'hE6});
        run(12'h025);
        chk("carry", carryFlag, 16'h0);
        gap();
    endtask : t_store
    task automatic t_rotate();
        run(12'h345);
        chk("work", workReg, 16'h00CC);
        chk("carry", carryFlag, 16'h1);
        chk("wrEn", fileWr.wrEn, 16'h0);
        run(12'h365);
        chk("fileWr", fileWr, {1'b1, 5'h05, 8'hCD});
        chk("work", workReg, 16'h00CC);
        gap();
    endtask : t_rotate
    task automatic t_option_idle();
        run(OPTION_WORD);
        chk("option", optionReg, 16'h00CC);
        chk("carry", carryFlag, 16'h1);
        run(IDLE_WORD);
        chk("pc", progCnt, pcOld + 11'h001);
        chk("work", workReg, 16'h00CC);
        chk("option", optionReg, 16'h00CC);
        chk("wrEn", fileWr.wrEn, 16'h0);
        run(12'hC5A);
        chk("pc", progCnt, pcOld + 11'h001);
        chk("work", workReg, 16'h00CC);
        gap();
    endtask : t_option_idle
    // mid-run reset clears state and stack
    task automatic t_reset();
        push(11'h2AB);
        rst_b = 1'b0;
        @(negedge core_clk);
        chk("pc", progCnt, 16'h0000);
        chk("option", optionReg, 16'h00FF);
        chk("work", workReg, 16'h0000);
        chk("carry", carryFlag, 16'h0);
        chk("flush", flushFetch, 16'h0);
        rst_b = 1'b1;
        run(12'h811);
        chk("work", workReg, 16'h0011);
        chk("pc", progCnt, 16'h0000);
        gap();
    endtask : t_reset
    // verdict
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    // main sequence
    initial begin
        repeat (10) @(negedge core_clk);
        rst_b = 1'b1;
        chk("option", optionReg, 16'h00FF);
        t_return();
        t_store();
        t_rotate();
        t_option_idle();
        t_reset();
        tally_and_finish();
    end
    // watchdog
    initial begin
        #40000;
        errTotal++;
        tally_and_finish();
    end
endmodule : cpu_move_return_rotate_ops_tb
